// ### core/dda_adapter.sv
// Adapter end: address registers, sector compare, data resync, CRC compare
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Hold five-bit requested sector from controller
// - Compare held sector to drive sector continuously
// - Controller may ignore sector equality
// - Nine-bit track: head bit plus cylinder
// - Cylinder limited to 203 positions
// - Track number is first word after sync
// - Decode three unit lines to one-hot eight
// - Controller waits for drive ready first
// - Index mark restarts sector count at zero
// - Write data registered, shifted under write clock
// - Read data registered before reaching controller
// - Addresses share serial link, load lines select
// - Four drive controls out, eight status in
// - All twelve control/status lines returned
// - Compare CRC, flag mismatch
// - Controller does serial conversion and resync
// - Controller link clock 320 ns period; divider gives 300 ns (six-cycle half periods)
// - Track starts at sector trailing edge, 640ns bits
module dda_adapter
    import dda_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    // Controller cable
    dda_link_if.adapter               link,
    // Drive side
    input  wire logic                 write_clk_i,
    input  wire logic                 drv_read_data_i,
    input  wire logic                 drv_read_clk_i,
    input  wire logic                 drv_sector_mark_i,
    input  wire logic                 drv_index_mark_i,
    input  wire logic [7:0]           drv_status_i,
    output logic [UNITS-1:0]          unit_sel_o,
    output logic                      head_sel_o,
    output logic [CYL_W-1:0]          cyl_addr_o,
    output logic                      cyl_valid_o,
    output logic [SECTOR_W-1:0]       sector_addr_o,
    output logic                      write_data_o,
    output logic [3:0]                drive_ctrl_o
);
    import dda_pkg::*;

    // Synchronisers: stage one is read only by stage two
    logic [6:0] s1_q, s2_q, s3_q;
    logic [6:0] raw;
    assign raw = {write_clk_i, link.xfer_clk, link.ser_data, link.ld_sector,
                  link.ld_track, link.ld_data, drv_read_clk_i};
    logic [1:0] mk1_q, mk2_q, mk3_q;
    logic       rd1_q, rd2_q;
    logic [7:0] st1_q, st2_q;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            mk1_q <= '0;
            mk2_q <= '0;
            mk3_q <= '0;
            rd1_q <= 1'b0;
            rd2_q <= 1'b0;
            st1_q <= '0;
            st2_q <= '0;
        end else begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            mk1_q <= {drv_sector_mark_i, drv_index_mark_i};
            mk2_q <= mk1_q;
            mk3_q <= mk2_q;
            rd1_q <= drv_read_data_i;
            rd2_q <= rd1_q;
            st1_q <= drv_status_i;
            st2_q <= st1_q;
        end
    end

    logic xclk_rise, wclk_rise, rclk_rise, sect_fall, index_rise;
    assign wclk_rise  = s2_q[6] & ~s3_q[6];
    assign xclk_rise  = s2_q[5] & ~s3_q[5];
    assign rclk_rise  = s2_q[0] & ~s3_q[0];
    // Trailing edge of the sector pulse starts a track
    assign sect_fall  = ~mk2_q[1] & mk3_q[1];
    assign index_rise = mk2_q[0] & ~mk3_q[0];

    // Address and data state
    logic [SECTOR_W-1:0] sect_q, sect_d;
    logic [TRACK_W-1:0]  trk_q, trk_d;
    logic [SECTOR_W-1:0] cnt_q, cnt_d;
    logic                idx_q, idx_d;
    logic [WORD_W-1:0]   sh_q, sh_d;
    logic [WORD_W-1:0]   wr_q, wr_d;
    logic [WORD_W-1:0]   rd_q, rd_d;
    logic [WORD_W-1:0]   rcrc_q, rcrc_d;
    logic                ldd_q, ldd_d;
    logic                eq_q, eq_d;
    logic                err_q, err_d;
    logic                wbit_q, wbit_d;
    logic                wph_q, wph_d;
    logic                rbit_q, rbit_d;
    logic [UNITS-1:0]    us_q, us_d;
    logic [3:0]          dc_q, dc_d;
    logic [CTRL_W-1:0]   cs_q, cs_d;
    logic                cv_q, cv_d;
    logic                rck_q, rck_d;

    always_comb begin
        sect_d = sect_q;
        trk_d  = trk_q;
        cnt_d  = cnt_q;
        idx_d  = idx_q;
        sh_d   = sh_q;
        wr_d   = wr_q;
        rd_d   = rd_q;
        rcrc_d = rcrc_q;
        ldd_d  = s2_q[1];
        err_d  = err_q;
        wbit_d = wbit_q;
        rbit_d = rd_q[WORD_W-1];
        rck_d  = s2_q[0];
        // Serial bits enter MSB first on the link clock
        if (xclk_rise && (s2_q[3] || s2_q[2] || s2_q[1])) begin
            sh_d = {sh_q[WORD_W-2:0], s2_q[4]};
            if (s2_q[3])
                sect_d = sh_d[SECTOR_W-1:0];
            if (s2_q[2])
                trk_d = sh_d[TRACK_W-1:0];
        end
        // Load beats a shift in the same cycle, so no word is lost
        // Otherwise one bit cell per two write clock rises
        if (ldd_q && !s2_q[1]) begin
            wr_d = sh_q;
        end else if (wclk_rise && wph_q) begin
            wbit_d = wr_q[WORD_W-1];
            wr_d   = {wr_q[WORD_W-2:0], 1'b0};
        end
        wph_d = wph_q ^ wclk_rise;
        // Read bits re-registered on the recovered clock
        if (rclk_rise) begin
            rd_d   = {rd_q[WORD_W-2:0], rd2_q};
            rcrc_d = rd_d;
        end
        // Index restarts the count; next mark is sector zero
        if (sect_fall) begin
            idx_d = 1'b0;
            if (idx_q || cnt_q == SECTOR_LAST)
                cnt_d = '0;
            else
                cnt_d = cnt_q + 5'h01;
        end
        // Set after clear, so a coincident index is not lost
        if (index_rise)
            idx_d = 1'b1;
        // Recorded CRC checked against controller's result
        if (link.crc_chk)
            err_d = (rcrc_q != link.crc_calc);
        eq_d = (sect_q == cnt_q);
        cv_d = (trk_q[CYL_W-1:0] <= CYL_MAX);
        dc_d = link.drive_ctrl;
        cs_d = {dc_q, st2_q[3:0], st2_q[7:4]};
        us_d = '0;
        us_d[link.unit_sel] = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sect_q <= SECTOR_RST;
            trk_q  <= TRACK_RST;
            cnt_q  <= SECTOR_RST;
            idx_q  <= 1'b0;
            sh_q   <= '0;
            wr_q   <= '0;
            rd_q   <= '0;
            rcrc_q <= '0;
            ldd_q  <= 1'b0;
            eq_q   <= 1'b0;
            err_q  <= 1'b0;
            wbit_q <= 1'b0;
            wph_q  <= 1'b0;
            rbit_q <= 1'b0;
            us_q   <= '0;
            dc_q   <= '0;
            cs_q   <= '0;
            cv_q   <= 1'b0;
            rck_q  <= 1'b0;
        end else begin
            sect_q <= sect_d;
            trk_q  <= trk_d;
            cnt_q  <= cnt_d;
            idx_q  <= idx_d;
            sh_q   <= sh_d;
            wr_q   <= wr_d;
            rd_q   <= rd_d;
            rcrc_q <= rcrc_d;
            ldd_q  <= ldd_d;
            eq_q   <= eq_d;
            err_q  <= err_d;
            wbit_q <= wbit_d;
            wph_q  <= wph_d;
            rbit_q <= rbit_d;
            us_q   <= us_d;
            dc_q   <= dc_d;
            cs_q   <= cs_d;
            cv_q   <= cv_d;
            rck_q  <= rck_d;
        end
    end

    assign unit_sel_o    = us_q;
    assign head_sel_o    = trk_q[HEAD_BIT];
    // Held track word is what a frame carries first after sync
    assign cyl_addr_o    = trk_q[CYL_W-1:0];
    assign cyl_valid_o   = cv_q;
    assign sector_addr_o = sect_q;
    assign write_data_o  = wbit_q;
    assign drive_ctrl_o  = dc_q;
    assign link.sector_eq            = eq_q;
    assign link.read_data            = rbit_q;
    assign link.recovered_read_clock = rck_q;
    assign link.crc_err              = err_q;
    assign link.ctrl_stat            = cs_q;
endmodule
`default_nettype wire

// ### core/dda_controller.sv
// Controller end: link clock divider and serial address/data sender
`timescale 1ns/10ps
`default_nettype none
module dda_controller
    import dda_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    // User request
    input  wire logic                 send_i,
    input  wire dda_load_e            send_kind_i,
    input  wire logic [WORD_W-1:0]    send_word_i,
    input  wire logic [UNIT_W-1:0]    unit_i,
    input  wire logic [3:0]           drive_ctrl_i,
    input  wire logic                 ignore_eq_i,
    input  wire logic [WORD_W-1:0]    crc_calc_i,
    input  wire logic                 crc_chk_i,
    output logic                      busy_o,
    output logic                      go_o,
    output logic                      crc_err_o,
    output logic [CTRL_W-1:0]         ctrl_stat_o,
    // Cable
    dda_link_if.controller            link
);
    import dda_pkg::*;

    typedef enum logic [1:0] {DDA_IDLE, DDA_SHIFT, DDA_END} dda_state_e;
    dda_state_e        st_q, st_d;
    logic [3:0]        div_q, div_d;
    logic              xck_q, xck_d;
    logic [WORD_W-1:0] sh_q, sh_d;
    logic [4:0]        bits_q, bits_d;
    dda_load_e         kind_q, kind_d;
    logic [2:0]        eq1_q, eq2_q;
    logic              go_q, go_d;
    logic [UNIT_W-1:0] un_q, un_d;
    logic [3:0]        dc_q, dc_d;
    logic [WORD_W-1:0] crc_q, crc_d;
    logic              chk_q, chk_d;
    logic              busy_q, busy_d;

    // Sector match, CRC error and ready bit from the adapter domain are resynchronised
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            eq1_q <= '0;
            eq2_q <= '0;
        end else begin
            eq1_q <= {link.sector_eq, link.crc_err, link.ctrl_stat[4]};
            eq2_q <= eq1_q;
        end
    end

    logic fall;
    logic rise;
    always_comb begin
        st_d   = st_q;
        div_d  = div_q;
        xck_d  = xck_q;
        sh_d   = sh_q;
        bits_d = bits_q;
        kind_d = kind_q;
        fall   = 1'b0;
        rise   = 1'b0;
        // Link clock from divider, 300 ns period
        if (div_q == 4'(XFER_HALF_CYC - 1)) begin
            div_d = '0;
            xck_d = ~xck_q;
            fall  = xck_q;
            rise  = ~xck_q;
        end else begin
            div_d = div_q + 4'h1;
        end
        unique case (st_q)
            DDA_IDLE: begin
                if (send_i && send_kind_i != DDA_LD_NONE) begin
                    st_d   = DDA_SHIFT;
                    sh_d   = send_word_i;
                    kind_d = send_kind_i;
                    // A rise on the loading edge already takes the MSB
                    bits_d = rise ? 5'(WORD_W - 1) : 5'(WORD_W);
                end
            end
            DDA_SHIFT: begin
                // Adapter samples on rises, bits move on falls
                if (rise)
                    bits_d = bits_q - 5'h01;
                if (fall && bits_q != 5'(WORD_W)) begin
                    if (bits_q == 5'h00)
                        st_d = DDA_END;
                    else
                        sh_d = {sh_q[WORD_W-2:0], 1'b0};
                end
            end
            DDA_END: begin
                // Load drops two cycles before the next rise: no 17th bit
                if (!xck_q && div_q == 4'(XFER_HALF_CYC - 3)) begin
                    st_d   = DDA_IDLE;
                    kind_d = DDA_LD_NONE;
                end
            end
        endcase
        busy_d = (st_d != DDA_IDLE);
        // Drive activity only when drive is ready
        dc_d  = eq2_q[0] ? drive_ctrl_i : 4'h0;
        // Sector match may be overridden
        go_d  = eq2_q[2] | ignore_eq_i;
        un_d  = unit_i;
        crc_d = crc_calc_i;
        chk_d = crc_chk_i;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q   <= DDA_IDLE;
            div_q  <= '0;
            xck_q  <= 1'b0;
            sh_q   <= '0;
            bits_q <= '0;
            kind_q <= DDA_LD_NONE;
            go_q   <= 1'b0;
            un_q   <= '0;
            dc_q   <= '0;
            crc_q  <= '0;
            chk_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            xck_q  <= xck_d;
            sh_q   <= sh_d;
            bits_q <= bits_d;
            kind_q <= kind_d;
            go_q   <= go_d;
            un_q   <= un_d;
            dc_q   <= dc_d;
            crc_q  <= crc_d;
            chk_q  <= chk_d;
            busy_q <= busy_d;
        end
    end

    assign link.xfer_clk            = xck_q;
    assign link.ser_data            = sh_q[WORD_W-1];
    assign link.ld_sector           = (kind_q == DDA_LD_SECTOR);
    assign link.ld_track            = (kind_q == DDA_LD_TRACK);
    assign link.ld_data             = (kind_q == DDA_LD_DATA);
    assign link.unit_sel            = un_q;
    assign link.returned_read_clock = link.recovered_read_clock;
    assign link.crc_calc            = crc_q;
    assign link.crc_chk             = chk_q;
    assign link.drive_ctrl          = dc_q;
    assign busy_o      = busy_q;
    assign go_o        = go_q;
    assign crc_err_o   = eq2_q[1];
    assign ctrl_stat_o = link.ctrl_stat;
endmodule
`default_nettype wire

// ### include/dda_link_if.sv
// Cable between the controller and the adapter
`timescale 1ns/10ps
`default_nettype none
interface dda_link_if;
    logic                       xfer_clk;
    logic                       ser_data;
    logic                       ld_sector;
    logic                       ld_track;
    logic                       ld_data;
    logic [dda_pkg::UNIT_W-1:0] unit_sel;
    logic                       sector_eq;
    logic                       read_data;
    logic                       recovered_read_clock;
    logic                       returned_read_clock;
    logic [dda_pkg::WORD_W-1:0] crc_calc;
    logic                       crc_chk;
    logic                       crc_err;
    logic [dda_pkg::CTRL_W-1:0] ctrl_stat;
    logic [3:0]                 drive_ctrl;
    modport adapter (
        input  xfer_clk, ser_data, ld_sector, ld_track, ld_data, unit_sel,
        input  returned_read_clock, crc_calc, crc_chk, drive_ctrl,
        output sector_eq, read_data, recovered_read_clock, crc_err,
        output ctrl_stat
    );
    modport controller (
        output xfer_clk, ser_data, ld_sector, ld_track, ld_data, unit_sel,
        output returned_read_clock, crc_calc, crc_chk, drive_ctrl,
        input  sector_eq, read_data, recovered_read_clock, crc_err,
        input  ctrl_stat
    );
endinterface
`default_nettype wire

// ### include/dda_pkg.sv
// Shared constants and types for the disc drive adapter link
package dda_pkg;
    localparam int unsigned SECTOR_W      = 5;
    localparam int unsigned TRACK_W       = 9;
    localparam int unsigned CYL_W         = 8;
    localparam int unsigned UNIT_W        = 3;
    localparam int unsigned UNITS         = 8;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned CTRL_W        = 12;
    localparam int unsigned SECTORS       = 20;
    localparam int unsigned CYLINDERS     = 203;
    localparam int unsigned HEAD_BIT      = 8;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned XFER_CLK_NS   = 320;
    localparam int unsigned BIT_CELL_NS   = 640;
    // Half period of the driven link clock, in mclk cycles
    localparam int unsigned XFER_HALF_CYC = XFER_CLK_NS / 2 / CLK_PERIOD_NS;
    localparam int unsigned BIT_CELL_CYC  = BIT_CELL_NS / CLK_PERIOD_NS;
    localparam logic [SECTOR_W-1:0] SECTOR_RST = 5'h00;
    localparam logic [TRACK_W-1:0]  TRACK_RST  = 9'h000;
    localparam logic [CYL_W-1:0]    CYL_MAX    = 8'hca;
    localparam logic [SECTOR_W-1:0] SECTOR_LAST = 5'h13;
    // Which address or data register a serial transfer loads
    typedef enum logic [1:0] {
        DDA_LD_NONE,
        DDA_LD_SECTOR,
        DDA_LD_TRACK,
        DDA_LD_DATA
    } dda_load_e;
endpackage

// ### tb/dda_link_asserts.sv
// Cable checks between the controller and adapter ends
`timescale 1ns/10ps
`default_nettype none
module dda_link_asserts (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Cable signals
    input  wire logic        xfer_clk,
    input  wire logic        ser_data,
    input  wire logic        ld_sector,
    input  wire logic        ld_track,
    input  wire logic        ld_data,
    input  wire logic [3:0]  drive_ctrl,
    input  wire logic [11:0] ctrl_stat
);
    logic       ld_any;
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    assign ld_any = ld_sector | ld_track | ld_data;
    // Load window length, counted because it runs past 8 cycles
    always_comb begin
        cnt_d = ld_any ? cnt_q + 9'h001 : 9'h000;
    end
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_hi;
        xfer_clk [*6];
    endsequence
    sequence s_lo;
        !xfer_clk [*6];
    endsequence
    property p_ld_excl;
        $onehot0({ld_sector, ld_track, ld_data});
    endproperty
    a_ld_excl: assert property (p_ld_excl)
        else $error("load lines overlap");
    property p_ld_hold;
        $rose(ld_any) |-> ld_any [*8];
    endproperty
    a_ld_hold: assert property (p_ld_hold)
        else $error("load line dropped early");
    property p_ld_len;
        $fell(ld_any) |-> cnt_q inside {[9'h0be:9'h0e6]};
    endproperty
    a_ld_len: assert property (p_ld_len)
        else $error("load window not one word long");
    property p_clk_hi;
        $rose(xfer_clk) |-> s_hi;
    endproperty
    a_clk_hi: assert property (p_clk_hi)
        else $error("link clock high phase short");
    property p_clk_lo;
        $fell(xfer_clk) |-> s_lo;
    endproperty
    a_clk_lo: assert property (p_clk_lo)
        else $error("link clock low phase short");
    // Data may only move while the clock is low, clear of its rise
    property p_ser_stable;
        ($changed(ser_data) && ld_any && $past(ld_any)) |-> !xfer_clk;
    endproperty
    a_ser_stable: assert property (p_ser_stable)
        else $error("serial data moved while clock high");
    property p_ready_gate;
        (!ctrl_stat[4]) [*6] |-> drive_ctrl == 4'h0;
    endproperty
    a_ready_gate: assert property (p_ready_gate)
        else $error("drive control sent while not ready");
    property p_ctrl_echo;
        $stable(drive_ctrl) [*8] |-> ctrl_stat[11:8] == drive_ctrl;
    endproperty
    a_ctrl_echo: assert property (p_ctrl_echo)
        else $error("drive control not returned");
endmodule
`default_nettype wire

// ### tb/tb_disc_drive_adapter.sv
// Bench driving the user sides of both link ends
`timescale 1ns/10ps
`default_nettype none
module tb_disc_drive_adapter;
    import dda_pkg::*;
    logic        mclk_i = 1'b0, resetn_i = 1'b0, write_clk_i = 1'b0;
    logic        send_i = 1'b0, ignore_eq_i = 1'b0, crc_chk_i = 1'b0;
    logic        rd_dat = 1'b0, rd_clk = 1'b0, sec_mk = 1'b0, idx_mk = 1'b0;
    dda_load_e   send_kind_i = DDA_LD_NONE;
    logic [15:0] send_word_i = 16'h0000, crc_calc_i = 16'h0000;
    logic [2:0]  unit_i = 3'h0;
    logic [3:0]  drive_ctrl_i = 4'h0;
    logic [7:0]  status = 8'h00;
    logic        busy_o, go_o, crc_err_o, head_sel_o, cyl_valid_o;
    logic        write_data_o;
    logic [11:0] ctrl_stat_o;
    logic [7:0]  unit_sel_o, cyl_addr_o;
    logic [4:0]  sector_addr_o;
    logic [3:0]  drive_ctrl_o;
    logic [63:0] got;
    logic [15:0] w;
    int          mismatches = 0;
    int          checks_done = 0;
    always #12.5 mclk_i = ~mclk_i;
    // Free-running write oscillator, unrelated to mclk
    always #160 write_clk_i = ~write_clk_i;
    dda_link_if lnk ();
    dda_controller dda_controller_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .send_i(send_i), .send_kind_i(send_kind_i), .send_word_i(send_word_i),
        .unit_i(unit_i), .drive_ctrl_i(drive_ctrl_i), .ignore_eq_i(ignore_eq_i),
        .crc_calc_i(crc_calc_i), .crc_chk_i(crc_chk_i), .busy_o(busy_o),
        .go_o(go_o), .crc_err_o(crc_err_o), .ctrl_stat_o(ctrl_stat_o),
        .link(lnk));
    dda_adapter dda_adapter_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .link(lnk), .write_clk_i(write_clk_i), .drv_read_data_i(rd_dat),
        .drv_read_clk_i(rd_clk), .drv_sector_mark_i(sec_mk),
        .drv_index_mark_i(idx_mk), .drv_status_i(status),
        .unit_sel_o(unit_sel_o), .head_sel_o(head_sel_o),
        .cyl_addr_o(cyl_addr_o), .cyl_valid_o(cyl_valid_o),
        .sector_addr_o(sector_addr_o), .write_data_o(write_data_o),
        .drive_ctrl_o(drive_ctrl_o));
    dda_link_asserts dda_link_asserts_inst (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .xfer_clk(lnk.xfer_clk),
        .ser_data(lnk.ser_data), .ld_sector(lnk.ld_sector),
        .ld_track(lnk.ld_track), .ld_data(lnk.ld_data),
        .drive_ctrl(lnk.drive_ctrl), .ctrl_stat(lnk.ctrl_stat));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // One word over the link; waits on busy with a bound
    task automatic send(input dda_load_e k, input logic [15:0] v);
        int n;
        n = 0;
        @(posedge mclk_i);
        send_kind_i <= k;
        send_word_i <= v;
        send_i <= 1'b1;
        @(posedge mclk_i);
        send_i <= 1'b0;
        @(posedge mclk_i);
        check("busy", busy_o, 1'b1);
        while (busy_o !== 1'b0 && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        check("word done", n < 400, 1'b1);
        tick(8);
    endtask
    task automatic mark(input logic idx);
        idx_mk <= idx;
        sec_mk <= !idx;
        tick(4);
        idx_mk <= 1'b0;
        sec_mk <= 1'b0;
        tick(12);
    endtask
    // Read clock runs only within the frame, 200 ns period
    task automatic rd_word(input logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            tick(2);
            rd_dat <= v[i];
            tick(2);
            rd_clk <= 1'b1;
            tick(4);
            rd_clk <= 1'b0;
        end
        tick(2);
        rd_dat <= ~v[0];
    endtask
    task automatic end_sim;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(8);
        resetn_i <= 1'b1;
        for (int u = 0; u < 8; u++) begin
            unit_i <= u[2:0];
            tick(6);
            check("unit_sel", unit_sel_o, 8'h01 << u);
        end
        send(DDA_LD_SECTOR, 16'hffe5);
        check("sector", sector_addr_o, 5'h05);
        for (int t = 0; t < 4; t++) begin
            w = (t == 0) ? 16'h01c9 : (t == 1) ? 16'h00ca :
                (t == 2) ? 16'h00cb : 16'h01ff;
            send(DDA_LD_TRACK, w);
            check("track", {head_sel_o, cyl_addr_o, cyl_valid_o},
                  {w[8:0], w[7:0] < CYLINDERS});
        end
        send(DDA_LD_SECTOR, 16'h0013);
        mark(1'b1);
        for (int k = 0; k < 21; k++) begin
            mark(1'b0);
            check("sector_eq", lnk.sector_eq, k == 19);
            check("go", go_o, k == 19);
        end
        ignore_eq_i <= 1'b1;
        tick(8);
        check("go ignored", go_o, 1'b1);
        ignore_eq_i <= 1'b0;
        drive_ctrl_i <= 4'hf;
        tick(12);
        check("gated", drive_ctrl_o, 4'h0);
        for (int b = 0; b < 8; b++) begin
            status <= 8'h01 | (8'h01 << b);
            drive_ctrl_i <= 4'h1 << b[1:0];
            tick(12);
            check("drive_ctrl", drive_ctrl_o, drive_ctrl_i);
            check("ctrl_stat", ctrl_stat_o,
                  {drive_ctrl_i, status[3:0], status[7:4]});
        end
        drive_ctrl_i <= 4'h8;
        send(DDA_LD_DATA, 16'hc35a);
        got = 64'h0;
        repeat (40) begin
            @(posedge write_clk_i);
            @(posedge write_clk_i);
            got = {got[62:0], write_data_o};
        end
        w = 16'h0000;
        for (int i = 0; i < 25; i++) begin
            if (got[i+:16] === 16'hc35a) begin
                w = 16'h0001;
            end
        end
        check("write data", w, 16'h0001);
        @(posedge mclk_i);
        drive_ctrl_i <= 4'h0;
        rd_word(16'h9e3b);
        crc_calc_i <= 16'h9e3a;
        crc_chk_i <= 1'b1;
        tick(12);
        check("crc mismatch", crc_err_o, 1'b1);
        crc_calc_i <= 16'h9e3b;
        tick(12);
        check("crc match", crc_err_o, 1'b0);
        crc_chk_i <= 1'b0;
        end_sim();
    end
    initial begin
        tick(60000);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
